// ==== inc/sdp_pkg.sv ====
// Shared widths and reset values for the dual-port RAM port logic
package sdp_pkg;
  localparam int SDP_PORTS = 2;
  localparam int SDP_ADDR_W = 15;
  localparam int SDP_DATA_W = 16;
  localparam int SDP_LANES = 2;
  localparam int SDP_LANE_W = 8;
  localparam int SDP_SYNC_STAGES = 3;
  localparam logic [SDP_ADDR_W-1:0] SDP_ADDR_ZERO = 15'h0000;
  localparam logic [SDP_ADDR_W-1:0] SDP_ADDR_STEP = 15'h0001;
  localparam logic [SDP_DATA_W-1:0] SDP_DATA_RST = 16'h0000;
  localparam logic SDP_MODE_FLOW = 1'b0;
  localparam logic SDP_MODE_PIPE = 1'b1;
endpackage : sdp_pkg

// ==== src/sdp_port_ram.sv ====
// Dual-port synchronous RAM with per-port counters, chip enables and output modes
// Functional notes
// R1: All port inputs sampled on rising clock; output enable acts asynchronously.
// R2: Deselected chip enables turn data outputs off from the next edge.
// R3: Address-load strobe low captures the external address every edge.
// R4: A high byte enable input keeps that read byte lane off.
// R5: Pipelined read racing an opposite write shows new data one cycle late.
// R6: Opposite write a cycle ahead is seen on the first pipelined read.
// R7: Idle cycle between read and write leaves the stored word unchanged.
// R8: Output drive state follows controls registered in the preceding cycle.
// R9: Load strobe and counter enable both high hold the internal address.
// R10: Internal address is external when loading, else counter output.
// R11: Counter clear adds no dead cycle; location zero is accessed.
// R12: Counter enable low increments address; that address is written.
// R13: Registers update on rising edge; array write is its own pulse.
// R14: One deselected cycle powers the port down.
// R15: Pipelined mode needs two selected cycles before outputs drive again.
// R16: Depth expansion: same address to all banks, select by chip enables.
// R17: Output mode select low is flow-through, high is pipelined, per port.
// R18: Output mode select is a static level, not a clocked signal.
// R19: Counter clear sampled low sets the address to zero for that access.
// R20: Flow-through data one cycle after address; pipelined one more.
`timescale 1ns/1ps
`default_nettype none
module sdp_port_ram
  import sdp_pkg::*;
#(
  parameter int ADDR_W = sdp_pkg::SDP_ADDR_W,
  parameter int DEPTH = 1 << sdp_pkg::SDP_ADDR_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Per-port controls, index 0 and 1 are the two ports
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_chip_sel_low_active_n,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_chip_sel_high_active,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_read_not_write,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_upper_byte_en_n,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_lower_byte_en_n,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_addr_load_strobe_n,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_counter_advance_en_n,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_counter_clear_n,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_out_en_n,
  input wire logic [sdp_pkg::SDP_PORTS-1:0] i_output_mode_select,
  // Per-port address and data
  input wire logic [sdp_pkg::SDP_PORTS-1:0][ADDR_W-1:0] i_addr,
  input wire logic [sdp_pkg::SDP_PORTS-1:0][sdp_pkg::SDP_DATA_W-1:0] i_data,
  // Per-port data outputs, one enable per byte lane
  output logic [sdp_pkg::SDP_PORTS-1:0][sdp_pkg::SDP_DATA_W-1:0] o_data,
  output logic [sdp_pkg::SDP_PORTS-1:0][sdp_pkg::SDP_LANES-1:0] o_data_oe,
  // Per-port status
  output logic [sdp_pkg::SDP_PORTS-1:0] o_port_standby,
  output logic [sdp_pkg::SDP_PORTS-1:0][ADDR_W-1:0] o_internal_addr
);
  import sdp_pkg::*;

  // Shared array, written by both ports
  logic [SDP_DATA_W-1:0] mem [DEPTH];

  // Per-port state
  logic [SDP_PORTS-1:0][ADDR_W-1:0] next_addr;
  logic [SDP_PORTS-1:0][ADDR_W-1:0] acc_addr;
  logic [SDP_PORTS-1:0] next_sel;
  logic [SDP_PORTS-1:0] sel_d1;
  logic [SDP_PORTS-1:0] acc_rd;
  logic [SDP_PORTS-1:0][SDP_LANES-1:0] acc_lane;
  logic [SDP_PORTS-1:0][SDP_LANES-1:0] lane_en;
  logic [SDP_PORTS-1:0][SDP_DATA_W-1:0] pipe_word;
  logic [SDP_PORTS-1:0] pipe_mode;
  logic [SDP_PORTS-1:0][SDP_SYNC_STAGES-1:0] mode_sync;
  logic [SDP_PORTS-1:0] wr_now;
  logic [SDP_PORTS-1:0][SDP_LANES-1:0] wr_lane;

  // Address selection: clear, then load, then advance, else hold
  function automatic logic [ADDR_W-1:0] pick_addr(input logic clr_n, input logic load_n,
      input logic adv_n, input logic [ADDR_W-1:0] ext, input logic [ADDR_W-1:0] cnt);
    logic [ADDR_W-1:0] res;
    res = cnt;
    if (!clr_n) begin
      res = SDP_ADDR_ZERO[ADDR_W-1:0];
    end else if (!load_n) begin
      res = ext;
    end else if (!adv_n) begin
      res = cnt + SDP_ADDR_STEP[ADDR_W-1:0];
    end
    return res;
  endfunction : pick_addr

  // Byte-lane merge of write data into a stored word
  function automatic logic [SDP_DATA_W-1:0] merge_word(input logic [SDP_DATA_W-1:0] old,
      input logic [SDP_DATA_W-1:0] wdat, input logic [SDP_LANES-1:0] lanes);
    logic [SDP_DATA_W-1:0] res;
    res = old;
    for (int l = 0; l < SDP_LANES; l++) begin
      if (lanes[l]) begin
        res[l*SDP_LANE_W +: SDP_LANE_W] = wdat[l*SDP_LANE_W +: SDP_LANE_W];
      end
    end
    return res;
  endfunction : merge_word

  // Decode of sampled controls, per port
  always_comb begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      next_sel[p] = !i_chip_sel_low_active_n[p] && i_chip_sel_high_active[p];
      next_addr[p] = pick_addr(i_counter_clear_n[p], i_addr_load_strobe_n[p],
                               i_counter_advance_en_n[p], i_addr[p], acc_addr[p]); // [R3] [R9] [R10] [R11] [R12] [R19]
      wr_lane[p] = {!i_upper_byte_en_n[p], !i_lower_byte_en_n[p]};
      wr_now[p] = next_sel[p] && !i_read_not_write[p];
    end
  end

  // Output mode level through three stages; change taken when last two agree
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      mode_sync[p] <= {mode_sync[p][SDP_SYNC_STAGES-2:0], i_output_mode_select[p]}; // [R18]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      if (i_rst) begin
        pipe_mode[p] <= SDP_MODE_FLOW;
      end else if (mode_sync[p][2] == mode_sync[p][1]) begin
        pipe_mode[p] <= mode_sync[p][2]; // [R17]
      end
    end
  end

  // Address register doubles as the counter, updated every edge
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      if (i_rst) begin
        acc_addr[p] <= SDP_ADDR_ZERO[ADDR_W-1:0];
      end else begin
        acc_addr[p] <= next_addr[p]; // [R1] [R13]
      end
    end
  end

  // Registered control state for the following cycle
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      if (i_rst) begin
        sel_d1[p] <= 1'b0;
        acc_rd[p] <= 1'b0;
        acc_lane[p] <= '0;
      end else begin
        sel_d1[p] <= next_sel[p];
        acc_rd[p] <= next_sel[p] && i_read_not_write[p];
        acc_lane[p] <= wr_lane[p];
      end
    end
  end

  // Array write on the sampling edge; port 1 wins a same-address clash
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      if (!i_rst && wr_now[p]) begin
        mem[next_addr[p]] <= merge_word(mem[next_addr[p]], i_data[p], wr_lane[p]); // [R12] [R13]
      end
    end
  end

  // Pipelined stage: word fetched at the address edge, so a same-edge write lands a cycle late
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      if (i_rst) begin
        pipe_word[p] <= SDP_DATA_RST;
      end else begin
        pipe_word[p] <= mem[next_addr[p]]; // [R5] [R6]
      end
    end
  end

  // Read data: flow-through reads at the address edge, pipelined one edge later
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      if (i_rst) begin
        o_data[p] <= SDP_DATA_RST;
      end else if (pipe_mode[p]) begin
        o_data[p] <= pipe_word[p]; // [R5] [R6] [R20]
      end else begin
        o_data[p] <= mem[next_addr[p]]; // [R20]
      end
    end
  end

  // Lane drive from prior controls; pipelined needs two selected edges
  always_ff @(posedge i_sys_clk) begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      if (i_rst) begin
        lane_en[p] <= '0;
      end else if (pipe_mode[p]) begin
        lane_en[p] <= (acc_rd[p] && next_sel[p]) ? acc_lane[p] : '0; // [R2] [R8] [R15] [R4]
      end else begin
        lane_en[p] <= (next_sel[p] && i_read_not_write[p]) ? wr_lane[p] : '0; // [R2] [R4] [R8]
      end
    end
  end

  // Asynchronous output enable gates the registered lane drive
  always_comb begin
    for (int p = 0; p < SDP_PORTS; p++) begin
      o_data_oe[p] = i_out_en_n[p] ? '0 : lane_en[p]; // [R1]
    end
  end

  // Standby after any deselected edge; internal address visible
  assign o_port_standby = ~sel_d1; // [R14]
  assign o_internal_addr = acc_addr;

  // Checks
  for (genvar gp = 0; gp < SDP_PORTS; gp++) begin : g_chk
    sequence s_deselect;
      !(!i_chip_sel_low_active_n[gp] && i_chip_sel_high_active[gp]);
    endsequence
    sequence s_load;
      i_counter_clear_n[gp] && !i_addr_load_strobe_n[gp];
    endsequence

    a_deselect_off: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R2]
      s_deselect |=> (o_data_oe[gp] == '0))
      else $error("outputs driven after deselect");
    a_load_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R3]
      s_load |=> (o_internal_addr[gp] == $past(i_addr[gp])))
      else $error("external address not loaded");
    a_counter_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R9]
      (i_counter_clear_n[gp] && i_addr_load_strobe_n[gp] && i_counter_advance_en_n[gp])
      |=> $stable(o_internal_addr[gp]))
      else $error("address moved while holding");
    a_counter_step: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R12]
      (i_counter_clear_n[gp] && i_addr_load_strobe_n[gp] && !i_counter_advance_en_n[gp])
      |=> (o_internal_addr[gp] == ADDR_W'($past(o_internal_addr[gp]) + 1)))
      else $error("counter did not advance by one");
    a_clear_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R19]
      !i_counter_clear_n[gp] |=> (o_internal_addr[gp] == '0))
      else $error("counter clear missed");
    // Output drive checks
    a_lane_masked: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R4]
      (!pipe_mode[gp] && i_upper_byte_en_n[gp]) |=> !o_data_oe[gp][1])
      else $error("masked upper lane driven");
    a_lane_masked_pipe: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R4]
      (pipe_mode[gp] && i_upper_byte_en_n[gp]) |=> ##1 !o_data_oe[gp][1])
      else $error("masked upper lane driven in pipelined mode");
    a_lower_masked: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R4]
      (!pipe_mode[gp] && i_lower_byte_en_n[gp]) |=> !o_data_oe[gp][0])
      else $error("masked lower lane driven");
    a_lower_masked_pipe: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R4]
      (pipe_mode[gp] && i_lower_byte_en_n[gp]) |=> ##1 !o_data_oe[gp][0])
      else $error("masked lower lane driven in pipelined mode");
    a_write_quiet: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R8]
      (!pipe_mode[gp] && next_sel[gp] && !i_read_not_write[gp]) |=> (o_data_oe[gp] == '0))
      else $error("write cycle drove outputs");
    a_write_quiet_pipe: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R8]
      (pipe_mode[gp] && next_sel[gp] && !i_read_not_write[gp]) |=> ##1 (o_data_oe[gp] == '0))
      else $error("pipelined write cycle drove outputs");
    a_pipe_reactivate: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R15]
      (pipe_mode[gp] ##0 s_deselect) ##1 pipe_mode[gp] |=> (o_data_oe[gp] == '0))
      else $error("pipelined output drove after one selected cycle");
    a_oe_async: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R1]
      i_out_en_n[gp] |-> (o_data_oe[gp] == '0))
      else $error("output enable ignored");
    a_standby_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R14]
      s_deselect |=> o_port_standby[gp])
      else $error("port not in standby");
    a_standby_leave: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R14]
      (!i_chip_sel_low_active_n[gp] && i_chip_sel_high_active[gp]) |=> !o_port_standby[gp])
      else $error("selected port left in standby");
    // Data path checks
    a_flow_read: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R20]
      (!pipe_mode[gp] && !wr_now[0] && !wr_now[1]) ##1 (pipe_mode[gp] == SDP_MODE_FLOW)
      |-> (o_data[gp] === mem[o_internal_addr[gp]]))
      else $error("flow-through data mismatch");
    a_pipe_stage: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R6]
      (pipe_mode[gp] && !wr_now[0] && !wr_now[1]) |=> (pipe_word[gp] === mem[o_internal_addr[gp]]))
      else $error("pipelined stage holds wrong word");
    a_pipe_out: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R20]
      pipe_mode[gp] |=> (o_data[gp] === $past(pipe_word[gp])))
      else $error("pipelined output not one stage behind");
    // Idle cycles leave the stored word alone
    a_idle_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst) // [R7]
      (!wr_now[0] && !wr_now[1]) |=> (mem[o_internal_addr[gp]] === $past(mem[next_addr[gp]])))
      else $error("stored word changed without a write");
  end : g_chk
endmodule : sdp_port_ram
`default_nettype wire

// ==== verification/sdp_bus_master.sv ====
// Bus master model that turns one command word into one port's pin levels
`timescale 1ns/1ps
`default_nettype none
module sdp_bus_master (
  // Command: sel, deselect form, read, lanes, load, advance, clear, address, data
  input wire logic [38:0] i_cmd,
  // Port pins
  output logic o_cs_n,
  output logic o_cs,
  output logic o_rnw,
  output logic o_ub_n,
  output logic o_lb_n,
  output logic o_ld_n,
  output logic o_adv_n,
  output logic o_clr_n,
  output logic [sdp_pkg::SDP_ADDR_W-1:0] o_addr,
  output logic [sdp_pkg::SDP_DATA_W-1:0] o_data
);
  import sdp_pkg::*;
  // Either chip enable may drop the port; banks share the address
  assign o_cs_n = !i_cmd[38] && !i_cmd[37];
  assign o_cs = i_cmd[38] || !i_cmd[37];
  // Levels for the edge sampler, all active low except read
  assign o_rnw = i_cmd[36];
  assign {o_ub_n, o_lb_n} = ~i_cmd[35:34];
  assign o_ld_n = !i_cmd[33];
  assign o_adv_n = !i_cmd[32];
  assign o_clr_n = !i_cmd[31];
  // Unused bus lines show inverted values, never stale ones
  assign o_addr = i_cmd[38] ? i_cmd[30:16] : ~i_cmd[30:16];
  assign o_data = (i_cmd[38] && !i_cmd[36]) ? i_cmd[15:0] : ~i_cmd[15:0];
endmodule : sdp_bus_master
`default_nettype wire

// ==== verification/sdp_port_ram_tb.sv ====
// Self-checking bench for the dual-port RAM port logic
`timescale 1ns/1ps
`default_nettype none
module sdp_port_ram_tb;
  import sdp_pkg::*;
  typedef struct packed {
    logic rd;
    logic [1:0] lanes;
    logic [14:0] a;
    logic [15:0] d;
  } sdp_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] oe_n = 2'b00;
  logic [1:0][38:0] cmd = '0;
  logic [1:0] cs_n, cs, rnw, ub_n, lb_n, ld_n, adv_n, clr_n, stby;
  logic [1:0][14:0] addr, iaddr;
  logic [1:0][15:0] wdat, q;
  logic [1:0][1:0] oe;
  int n_errors = 0;
  int n_tests = 0;
  // Port 0 rows: writes, partial lane write, lane-masked reads
  sdp_row_t rows [9] = '{'{1'b0, 2'b11, 15'h0010, 16'hA5C3}, '{1'b0, 2'b11, 15'h0011, 16'hFFFF},
    '{1'b0, 2'b10, 15'h0011, 16'h1234}, '{1'b0, 2'b11, 15'h0000, 16'h0F0F},
    '{1'b0, 2'b11, 15'h0020, 16'h2222}, '{1'b0, 2'b11, 15'h0021, 16'h3333},
    '{1'b1, 2'b10, 15'h0011, 16'h12FF}, '{1'b1, 2'b01, 15'h0011, 16'h12FF},
    '{1'b1, 2'b11, 15'h0010, 16'hA5C3}};
  always #10 i_sys_clk = ~i_sys_clk;
  for (genvar p = 0; p < 2; p++) begin : g_m
    sdp_bus_master i_m (.i_cmd(cmd[p]), .o_cs_n(cs_n[p]), .o_cs(cs[p]), .o_rnw(rnw[p]),
      .o_ub_n(ub_n[p]), .o_lb_n(lb_n[p]), .o_ld_n(ld_n[p]), .o_adv_n(adv_n[p]),
      .o_clr_n(clr_n[p]), .o_addr(addr[p]), .o_data(wdat[p]));
  end
  // Port 0 flow-through, port 1 pipelined, strap held static
  sdp_port_ram i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_chip_sel_low_active_n(cs_n),
    .i_chip_sel_high_active(cs), .i_read_not_write(rnw), .i_upper_byte_en_n(ub_n),
    .i_lower_byte_en_n(lb_n), .i_addr_load_strobe_n(ld_n), .i_counter_advance_en_n(adv_n),
    .i_counter_clear_n(clr_n), .i_out_en_n(oe_n), .i_output_mode_select(2'b10),
    .i_addr(addr), .i_data(wdat), .o_data(q), .o_data_oe(oe), .o_port_standby(stby),
    .o_internal_addr(iaddr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One command per edge, set by the edge itself
  task automatic go(input int p, input logic [7:0] c, input logic [14:0] a = '0,
                    input logic [15:0] d = '0);
    @(posedge i_sys_clk);
    cmd[p] <= {c, a, d};
  endtask : go
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    logic [15:0] m;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1 chk({stby, oe, iaddr[0]}, {6'b110000, 15'h0000});
    foreach (rows[i]) begin
      @(posedge i_sys_clk);
      cmd[0] <= {2'b10, rows[i].rd, rows[i].lanes, 3'b100, rows[i].a, rows[i].d};
      @(posedge i_sys_clk);
      #1;
      m = {{8{rows[i].lanes[1]}}, {8{rows[i].lanes[0]}}};
      chk(oe[0], rows[i].rd ? rows[i].lanes : 2'b00);
      chk(iaddr[0], rows[i].a);
      if (rows[i].rd) chk(q[0] & m, rows[i].d & m);
    end
    // Counter load, advance, hold, clear, write with advance
    go(0, 8'hBC, 15'h0020);
    go(0, 8'hBA);
    #1 chk({iaddr[0], q[0]}, {15'h0020, 16'h2222});
    go(0, 8'hB8);
    #1 chk({iaddr[0], q[0]}, {15'h0021, 16'h3333});
    go(0, 8'hB9);
    #1 chk({iaddr[0], q[0]}, {15'h0021, 16'h3333});
    go(0, 8'h9A, 15'h0000, 16'hBEEF);
    #1 chk({iaddr[0], q[0]}, {15'h0000, 16'h0F0F});
    go(0, 8'hBC, 15'h0001);
    #1 chk({iaddr[0], oe[0]}, {15'h0001, 2'b00});
    // Both deselect forms, then flow-through reactivation
    go(0, 8'h00);
    #1 chk({oe[0], q[0]}, {2'b11, 16'hBEEF});
    go(0, 8'h40);
    #1 chk({stby[0], oe[0]}, 3'b100);
    go(0, 8'hBC, 15'h0010);
    #1 chk({stby[0], oe[0]}, 3'b100);
    go(0, 8'hBC, 15'h0010);
    #1 chk({stby[0], oe[0], q[0]}, {3'b011, 16'hA5C3});
    @(posedge i_sys_clk);
    oe_n[0] <= 1'b1;
    #1 chk(oe[0], 2'b00);
    @(posedge i_sys_clk);
    oe_n[0] <= 1'b0;
    #1 chk(oe[0], 2'b11);
    // Opposite-port write ahead of a pipelined read
    go(0, 8'h9C, 15'h0030, 16'h5A5A);
    @(posedge i_sys_clk);
    cmd[0] <= '0;
    cmd[1] <= {8'hBC, 15'h0030, 16'h0000};
    @(posedge i_sys_clk);
    #1 chk(oe[1], 2'b00);
    @(posedge i_sys_clk);
    #1 chk({oe[1], q[1]}, {2'b11, 16'h5A5A});
    // Same-edge opposite write reaches the pipelined read one cycle late
    @(posedge i_sys_clk);
    cmd[0] <= {8'h9C, 15'h0010, 16'h6B6B};
    cmd[1] <= {8'hBC, 15'h0010, 16'h0000};
    @(posedge i_sys_clk);
    cmd[0] <= '0;
    @(posedge i_sys_clk);
    #1 chk(q[1], 16'hA5C3);
    @(posedge i_sys_clk);
    #1 chk(q[1], 16'h6B6B);
    // Reset in mid-run, then release
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    cmd[1] <= '0;
    @(posedge i_sys_clk);
    #1 chk({stby, oe}, 6'b110000);
    @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk({stby, oe}, 6'b110000);
    chk(iaddr, 30'h0);
    tally_and_finish();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (400) @(posedge i_sys_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule : sdp_port_ram_tb
`default_nettype wire
